// File: core/aux_adc_pkg.sv
/*
  shared constants and types for the auxiliary converter sequencer.
  assumes a 50 MHz hclk and a 32-bit ahb-lite register bus.
*/
package aux_adc_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CLK_HZ_DEF = 1000000000 / CLK_PERIOD_NS;

  // register indexes; byte address is four times the index
  localparam logic [14:0] IDX_RESULT = 15'h402D;
  localparam logic [14:0] IDX_CONTROL = 15'h402E;
  localparam logic [14:0] IDX_SOURCE = 15'h402F;
  localparam logic [14:0] IDX_INT_STAT = 15'h4040;
  localparam logic [14:0] IDX_INT_MASK = 15'h4041;

  // control field positions
  localparam int unsigned CTL_ON_BIT = 15;
  localparam int unsigned CTL_GO_BIT = 14;
  localparam int unsigned CTL_KEEP_BIT = 12;
  localparam int unsigned RATE_LSB = 0;
  localparam int unsigned RATE_W = 6;

  // rate codes
  localparam logic [5:0] RATE_MANUAL = 6'h00;
  localparam logic [5:0] RATE_RESERVED = 6'h20;
  localparam int unsigned RATE_SLOW_MUL = 2;
  localparam int unsigned RATE_FAST_MUL = 16;

  // sources, result layout
  localparam int unsigned NUM_SRC = 11;
  localparam int unsigned SRC_CODE_W = 4;
  localparam int unsigned DATA_W = 12;

  // interrupt bits
  localparam int unsigned INT_W = 2;
  localparam int unsigned INT_DONE_BIT = 0;
  localparam int unsigned INT_OVR_BIT = 1;

  // reset values
  localparam logic [10:0] SRC_RST = 11'h000;
  localparam logic [5:0] RATE_RST = 6'h00;
  localparam logic [1:0] INT_RST = 2'h0;

  // ahb
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // control fields
  typedef struct packed {
    logic converter_on;
    logic convert_go;
    logic sleep_keep_on;
    logic [RATE_W-1:0] rate;
  } ctrl_t;

  // request to the analogue core
  typedef struct packed {
    logic start;
    logic [SRC_CODE_W-1:0] source;
  } conv_req_t;

  // answer from the analogue core
  typedef struct packed {
    logic done;
    logic [DATA_W-1:0] data;
  } conv_res_t;

  // result register
  typedef struct packed {
    logic [SRC_CODE_W-1:0] source;
    logic [DATA_W-1:0] value;
  } result_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WAIT = 3'b010,
    S_CONV = 3'b100
  } seq_state_t;

endpackage

// File: core/rate_pacer.sv
/*
  rate pacer: pulses tick at the pace chosen by the rate code.
  assumes run comes from logic on hclk; no divider, uses a phase
  accumulator that adds samples per second each cycle.
*/
`timescale 1ns/10ps
module rate_pacer #(
  parameter int unsigned CLK_HZ = aux_adc_pkg::CLK_HZ_DEF,
  parameter int unsigned ACC_W = 27
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic run,
  input wire logic [aux_adc_pkg::RATE_W-1:0] code,
  output logic tick
);
  import aux_adc_pkg::*;

  logic [ACC_W-1:0] acc_q, acc_d; // phase accumulator
  logic tick_q, tick_d; // one-cycle trigger
  logic [ACC_W-1:0] step; // samples per second
  logic [ACC_W-1:0] sum;

  ////////////////////////////////////////////////////////////////////
  // decode the rate code into samples per second
  always_comb begin
    step = '0;
    if (code == RATE_MANUAL || code == RATE_RESERVED) begin
      step = '0;
    end else if (code < RATE_RESERVED) begin
      step = ACC_W'(code) * ACC_W'(RATE_SLOW_MUL);
    end else begin
      step = ACC_W'(code - RATE_RESERVED) * ACC_W'(RATE_FAST_MUL);
    end
    sum = acc_q + step;
    acc_d = acc_q;
    tick_d = 1'b0;
    if (!run || step == '0) begin
      acc_d = '0; // restart phase when paused
    end else if (sum >= ACC_W'(CLK_HZ)) begin
      acc_d = sum - ACC_W'(CLK_HZ);
      tick_d = 1'b1;
    end else begin
      acc_d = sum;
    end
  end

  // register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

  // a tick only follows a valid nonzero rate code
  property p_tick_code;
    @(posedge hclk) disable iff (!hresetn)
      tick_q |-> $past(run) && $past(code) != RATE_MANUAL
        && $past(code) != RATE_RESERVED;
  endproperty
  a_tick_code: assert property (p_tick_code)
    else $error("pacer ticked with a manual or reserved code");

endmodule

// File: core/aux_adc_conversion_sequencer.sv
/*
  auxiliary converter sequencer: ahb-lite register slave, paced and
  manual triggers, round-robin source pick, touch interleave, result
  register and interrupt.
  assumes pwr_off, pwr_sleep, tp_busy and conv_res come from logic on
  hclk; the analogue core answers each start with one done pulse.
*/
`timescale 1ns/10ps
module aux_adc_conversion_sequencer #(
  parameter int unsigned CLK_HZ = aux_adc_pkg::CLK_HZ_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic pwr_off,
  input wire logic pwr_sleep,
  input wire logic tp_busy,
  input wire aux_adc_pkg::conv_res_t conv_res,
  output aux_adc_pkg::conv_req_t conv_req,
  output logic irq
);
  import aux_adc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // declarations
  ctrl_t ctrl_q, ctrl_d; // control register
  logic [NUM_SRC-1:0] src_q, src_d; // source enables
  result_t res_q, res_d; // last result
  logic [INT_W-1:0] stat_q, stat_d; // sticky events
  logic [INT_W-1:0] mask_q, mask_d; // interrupt enables
  logic irq_q, irq_d;
  seq_state_t state_q, state_d;
  logic [SRC_CODE_W-1:0] last_q, last_d; // index last measured
  conv_req_t req_q, req_d;
  logic wr_q, wr_d; // data phase is a write
  logic [14:0] idx_q, idx_d; // data phase register index
  logic [31:0] rdata_q, rdata_d;
  logic active; // converter may run now
  logic any_src; // at least one source enabled
  logic auto_mode; // paced operation
  logic tick; // paced trigger
  logic addr_ok; // address phase accepted
  logic [INT_W-1:0] ev; // events this cycle
  logic [SRC_CODE_W-1:0] next_idx;
  logic go_clr; // sequencer drops a manual go

  ////////////////////////////////////////////////////////////////////
  // find the next enabled source after the last one measured
  function automatic logic [SRC_CODE_W-1:0] pick_next(
    input logic [NUM_SRC-1:0] sel,
    input logic [SRC_CODE_W-1:0] last
  );
    logic [SRC_CODE_W-1:0] j;
    logic found;
    pick_next = last;
    found = 1'b0;
    j = last;
    for (int i = 0; i < NUM_SRC; i++) begin
      j = (j == SRC_CODE_W'(NUM_SRC - 1)) ? '0 : j + 1'b1;
      if (!found && sel[j]) begin
        pick_next = j;
        found = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // run conditions
  always_comb begin
    active = ctrl_q.converter_on && !pwr_off
      && !(pwr_sleep && !ctrl_q.sleep_keep_on);
    any_src = |src_q;
    auto_mode = ctrl_q.rate != RATE_MANUAL;
    next_idx = pick_next(src_q, last_q);
  end

  // pacer for automatic mode
  rate_pacer #(
    .CLK_HZ(CLK_HZ)
  ) u_pacer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .run(active && any_src && auto_mode && ctrl_q.convert_go),
    .code(ctrl_q.rate),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    state_d = state_q;
    last_d = last_q;
    req_d = '0;
    res_d = res_q;
    ev = '0;
    go_clr = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (active && any_src) begin
          if (auto_mode ? tick : ctrl_q.convert_go) begin
            state_d = S_WAIT;
          end
        end else if (!auto_mode && ctrl_q.convert_go) begin
          go_clr = 1'b1;
        end
      end
      S_WAIT: begin
        if (!active || !any_src) begin
          state_d = S_IDLE;
          if (!auto_mode) begin
            go_clr = 1'b1;
          end
        end else if (!tp_busy) begin
          // one source per trigger
          req_d.start = 1'b1;
          req_d.source = next_idx + 1'b1;
          last_d = next_idx;
          state_d = S_CONV;
        end
      end
      S_CONV: begin
        if (conv_res.done) begin
          res_d.source = req_q.source;
          res_d.value = conv_res.data;
          ev[INT_DONE_BIT] = 1'b1;
          state_d = S_IDLE;
          if (!auto_mode) begin
            go_clr = 1'b1;
          end
        end else begin
          req_d.source = req_q.source;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    // a paced trigger that finds us busy is lost
    if (tick && state_q != S_IDLE) begin
      ev[INT_OVR_BIT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // ahb-lite slave next values
  always_comb begin
    addr_ok = hsel && hready && htrans[1] && hsize == HSIZE_WORD;
    wr_d = addr_ok && hwrite;
    idx_d = haddr[16:2];
    src_d = src_q;
    mask_d = mask_q;
    stat_d = stat_q;
    ctrl_d = ctrl_q;
    // a finished or refused manual go drops before any write
    ctrl_d.convert_go = ctrl_q.convert_go && !go_clr;
    // set wins over a write-one clear
    if (wr_q && idx_q == IDX_INT_STAT) begin
      stat_d = stat_q & ~hwdata[INT_W-1:0];
    end
    stat_d = stat_d | ev;
    if (wr_q && idx_q == IDX_INT_MASK) begin
      mask_d = hwdata[INT_W-1:0];
    end
    if (wr_q && idx_q == IDX_SOURCE) begin
      src_d = hwdata[NUM_SRC-1:0];
    end
    if (wr_q && idx_q == IDX_CONTROL) begin
      ctrl_d.converter_on = hwdata[CTL_ON_BIT];
      ctrl_d.sleep_keep_on = hwdata[CTL_KEEP_BIT];
      ctrl_d.rate = hwdata[RATE_LSB +: RATE_W];
      // a go written while a manual conversion runs leaves the go bit unchanged
      if (!(state_q != S_IDLE && !auto_mode && hwdata[CTL_GO_BIT])) begin
        ctrl_d.convert_go = hwdata[CTL_GO_BIT];
      end
    end
    if (pwr_off) begin
      ctrl_d.converter_on = 1'b0;
    end
    irq_d = |(stat_d & mask_d);
    // read data is prepared in the address phase
    rdata_d = '0;
    if (addr_ok && !hwrite) begin
      case (haddr[16:2])
        IDX_RESULT: rdata_d[15:0] = res_q;
        IDX_CONTROL: begin
          rdata_d[CTL_ON_BIT] = ctrl_q.converter_on;
          rdata_d[CTL_GO_BIT] = ctrl_q.convert_go;
          rdata_d[CTL_KEEP_BIT] = ctrl_q.sleep_keep_on;
          rdata_d[RATE_LSB +: RATE_W] = ctrl_q.rate;
        end
        IDX_SOURCE: rdata_d[NUM_SRC-1:0] = src_q;
        IDX_INT_STAT: rdata_d[INT_W-1:0] = stat_q;
        IDX_INT_MASK: rdata_d[INT_W-1:0] = mask_q;
        default: rdata_d = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= '{1'b0, 1'b0, 1'b0, RATE_RST};
      src_q <= SRC_RST;
      res_q <= '0;
      stat_q <= INT_RST;
      mask_q <= INT_RST;
      irq_q <= 1'b0;
      state_q <= S_IDLE;
      last_q <= SRC_CODE_W'(NUM_SRC - 1);
      req_q <= '0;
      wr_q <= 1'b0;
      idx_q <= '0;
      rdata_q <= '0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      src_q <= src_d;
      res_q <= res_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      state_q <= state_d;
      last_q <= last_d;
      req_q <= req_d;
      wr_q <= wr_d;
      idx_q <= idx_d;
      rdata_q <= rdata_d;
    end
  end

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = rdata_q;
  assign conv_req = req_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_off_clears;
    @(posedge hclk) disable iff (!hresetn)
      pwr_off && ce |=> !ctrl_q.converter_on;
  endproperty
  a_off_clears: assert property (p_off_clears)
    else $error("enable survived the off state");

  property p_sleep_quiet;
    @(posedge hclk) disable iff (!hresetn)
      pwr_sleep && !ctrl_q.sleep_keep_on && ce |=> !req_q.start;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("conversion started in sleep without retention");

  property p_auto_trigger;
    @(posedge hclk) disable iff (!hresetn)
      ce && tick && state_q == S_IDLE && active && any_src && auto_mode
        |=> state_q == S_WAIT;
  endproperty
  a_auto_trigger: assert property (p_auto_trigger)
    else $error("paced trigger not taken");

  property p_manual_clear;
    @(posedge hclk) disable iff (!hresetn)
      ce && state_q == S_CONV && conv_res.done && !auto_mode
        && !(wr_q && idx_q == IDX_CONTROL) |=> !ctrl_q.convert_go;
  endproperty
  a_manual_clear: assert property (p_manual_clear)
    else $error("go bit not cleared after manual conversion");

  property p_touch_hold;
    @(posedge hclk) disable iff (!hresetn)
      state_q == S_WAIT && tp_busy |=> !req_q.start;
  endproperty
  a_touch_hold: assert property (p_touch_hold)
    else $error("conversion started during a touch set");

  property p_single_start;
    @(posedge hclk) disable iff (!hresetn)
      req_q.start |=> !req_q.start && state_q != S_WAIT;
  endproperty
  a_single_start: assert property (p_single_start)
    else $error("start pulse longer than one cycle");

  property p_start_enabled;
    @(posedge hclk) disable iff (!hresetn)
      req_q.start |-> $past(src_q[next_idx]) && $past(active);
  endproperty
  a_start_enabled: assert property (p_start_enabled)
    else $error("start on disabled converter or source");

  property p_code_range;
    @(posedge hclk) disable iff (!hresetn)
      req_q.start |-> req_q.source >= 4'h1 && req_q.source <= 4'hB;
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("source code out of range");

  property p_result_store;
    @(posedge hclk) disable iff (!hresetn)
      ce && state_q == S_CONV && conv_res.done
        |=> res_q.value == $past(conv_res.data)
        && res_q.source == $past(req_q.source);
  endproperty
  a_result_store: assert property (p_result_store)
    else $error("result register not updated");

  c_manual: cover property (@(posedge hclk)
    req_q.start && !auto_mode ##[1:50] state_q == S_IDLE);
  c_auto: cover property (@(posedge hclk) tick ##1 state_q == S_WAIT);
  c_touch: cover property (@(posedge hclk)
    state_q == S_WAIT && tp_busy ##1 req_q.start);
  c_irq: cover property (@(posedge hclk) $rose(irq_q));

endmodule

// File: testbench/analog_core_model.sv
/*
  behavioural analogue core: answers every start with one done pulse
  after lat idle cycles. assumes the sequencer holds the source from
  start until done and issues starts only on hclk.
*/
`timescale 1ns/10ps
module analog_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] lat,
  input wire aux_adc_pkg::conv_req_t conv_req,
  output aux_adc_pkg::conv_res_t conv_res
);
  import aux_adc_pkg::*;

  logic busy_q; // conversion under way
  logic [3:0] wait_q; // idle cycles left
  logic [3:0] src_q; // source being measured
  logic [11:0] noise_q; // data outside done keeps moving

  ////////////////////////////////////////////////////////////////////
  // conversion timing; no stale value lingers on data between pulses
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      src_q <= 4'h0;
      noise_q <= 12'h000;
      conv_res <= '0;
    end else begin
      noise_q <= noise_q + 12'h5A7;
      conv_res.done <= 1'b0;
      conv_res.data <= noise_q;
      if (conv_req.start) begin
        busy_q <= 1'b1;
        wait_q <= lat;
        src_q <= conv_req.source;
      end else if (busy_q && wait_q == 4'h0) begin
        conv_res.done <= 1'b1;
        conv_res.data <= {src_q, 8'h3C};
        busy_q <= 1'b0;
      end else if (busy_q) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule

// File: testbench/aux_adc_conversion_sequencer_tb_top.sv
/*
  self-checking bench for the converter sequencer: ahb-lite master
  tasks, queued expectations checked by a monitor process.
  assumes a shortened CLK_HZ so one second is 2000 cycles.
*/
`timescale 1ns/10ps
module aux_adc_conversion_sequencer_tb_top;
  import aux_adc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic pwr_off, pwr_sleep, tp_busy, rd_dp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0] lat;
  conv_res_t conv_res;
  conv_req_t conv_req;
  logic [31:0] exp_rd[$]; // expected read data
  logic [3:0] exp_src[$]; // expected source per start
  logic [3:0] codes[$];
  logic [10:0] src;
  logic [5:0] rates[3];
  int n_start, err_total, check_count, cnt, n0, sps;
  int unsigned r;
  bit free_run; // paced mode: starts are counted, not queued

  aux_adc_conversion_sequencer #(.CLK_HZ(2000))
    aux_adc_conversion_sequencer_i (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pwr_off(pwr_off), .pwr_sleep(pwr_sleep),
    .tp_busy(tp_busy), .conv_res(conv_res), .conv_req(conv_req),
    .irq(irq));
  analog_core_model analog_core_model_i (.hclk(hclk),
    .hresetn(hresetn), .lat(lat), .conv_req(conv_req),
    .conv_res(conv_res));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////
  // compare, verdict and bounded waits
  task automatic chk_val(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_for(input bit use_done);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((use_done ? conv_res.done : hreadyout) !== 1'b1 && n < 300);
    if (n >= 300) begin
      err_total++;
      $display("Error wait expected answer seen timeout");
      complete_run();
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  // ahb-lite single word transfer; read data checked by the monitor
  task automatic bus(input logic wr, input logic [14:0] idx,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {15'h0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_for(1'b0);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    rd_dp <= !wr;
    wait_for(1'b0);
    chk_val("hresp", 32'h0, {31'h0, hresp});
    rd_dp <= 1'b0;
  endtask

  task automatic rd(input logic [14:0] idx, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, idx, 32'h00000000);
  endtask

  // irq is looked at away from the edge, then drive resumes on posedge
  task automatic chk_irq(input logic e);
    repeat (2) @(negedge hclk);
    chk_val("irq", {31'h0, e}, {31'h0, irq});
    @(posedge hclk);
  endtask

  // one manual conversion; go must read back cleared afterwards
  task automatic manual(input logic [3:0] code, input logic [31:0] ctl);
    exp_src.push_back(code);
    lat <= 4'($urandom_range(0, 8));
    bus(1'b1, IDX_CONTROL, ctl);
    wait_for(1'b1);
    repeat (2) @(posedge hclk);
    rd(IDX_CONTROL, ctl & 32'hFFFFBFFF);
    rd(IDX_RESULT, {16'h0000, code, code, 8'h3C});
  endtask

  ////////////////////////////////////////////////////////////////////
  // monitor: takes the oldest note off a queue on a read data phase or a start
  always @(posedge hclk) begin
    if (rd_dp === 1'b1 && exp_rd.size() > 0)
      chk_val("hrdata", exp_rd.pop_front(), hrdata);
    if (conv_req.start === 1'b1) begin
      n_start++;
      if (exp_src.size() > 0)
        chk_val("source", {28'h0, exp_src.pop_front()},
                {28'h0, conv_req.source});
      else if (!free_run)
        chk_val("unexpected start", 32'h0, 32'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    r = $urandom(41384);
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {pwr_off, pwr_sleep, tp_busy, lat, rd_dp, free_run} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(IDX_CONTROL, 32'h0);
    rd(IDX_SOURCE, 32'h0);
    rd(IDX_RESULT, 32'h0);
    rd(15'h0100, 32'h0);
    // random subset, measured one source per trigger, in turn
    src = 11'($urandom);
    if (src == 11'h000)
      src = 11'h481;
    for (int i = 0; i < NUM_SRC; i++)
      if (src[i])
        codes.push_back(4'(i + 1));
    bus(1'b1, IDX_SOURCE, {21'h0, src});
    rd(IDX_SOURCE, {21'h0, src});
    bus(1'b1, IDX_INT_MASK, 32'h1);
    for (int i = 0; i <= codes.size(); i++) begin
      manual(codes[i % codes.size()], 32'h0000C000);
      chk_irq(1'b1);
      bus(1'b1, IDX_INT_STAT, 32'h1);
      chk_irq(1'b0);
    end
    // touch set in progress holds the measurement back
    bus(1'b1, IDX_SOURCE, 32'h100);
    tp_busy <= 1'b1;
    bus(1'b1, IDX_CONTROL, 32'h0000C000);
    repeat (30) @(posedge hclk);
    exp_src.push_back(4'h9);
    tp_busy <= 1'b0;
    wait_for(1'b1);
    repeat (2) @(posedge hclk);
    rd(IDX_CONTROL, 32'h00008000);
    // go without enable, then with no source: nothing starts
    bus(1'b1, IDX_CONTROL, 32'h00004000);
    repeat (30) @(posedge hclk);
    rd(IDX_CONTROL, 32'h0);
    bus(1'b1, IDX_SOURCE, 32'h0);
    bus(1'b1, IDX_CONTROL, 32'h0000C000);
    repeat (30) @(posedge hclk);
    rd(IDX_CONTROL, 32'h00008000);
    // sleep blocks unless retention is set
    bus(1'b1, IDX_SOURCE, 32'h100);
    pwr_sleep <= 1'b1;
    bus(1'b1, IDX_CONTROL, 32'h0000C000);
    repeat (30) @(posedge hclk);
    rd(IDX_CONTROL, 32'h00008000);
    manual(4'h9, 32'h0000D000);
    pwr_sleep <= 1'b0;
    // off state drops the enable
    pwr_off <= 1'b1;
    @(posedge hclk);
    pwr_off <= 1'b0;
    rd(IDX_CONTROL, 32'h00001000);
    // paced mode: starts in one second match the rate code
    free_run = 1'b1;
    rates[0] = 6'($urandom_range(1, 31));
    rates[1] = 6'h21;
    rates[2] = 6'h28;
    foreach (rates[k]) begin
      lat <= 4'h2;
      bus(1'b1, IDX_CONTROL, {16'h0, 10'h300, rates[k]});
      n0 = n_start;
      repeat (2000) @(posedge hclk);
      cnt = n_start - n0;
      sps = rates[k] < 6'h20 ? 2 * rates[k] : 16 * (rates[k] - 32);
      chk_val("starts per second", sps,
              (cnt + 1 >= sps && cnt <= sps + 1) ? sps : cnt);
      rd(IDX_CONTROL, {16'h0, 10'h300, rates[k]});
      bus(1'b1, IDX_CONTROL, 32'h00008000);
      repeat (20) @(posedge hclk);
    end
    free_run = 1'b0;
    repeat (40) @(posedge hclk);
    complete_run();
  end
endmodule
